// ==== rtl/sram_spi_pkg.sv ====
package sram_spi_pkg;
    // ----------------------------------------------------------------
    // instruction codes, nine bits with the optional leading zero
    // ----------------------------------------------------------------
    localparam logic [8:0] CMD_READ = 9'h003;
    localparam logic [8:0] CMD_WRITE = 9'h002;
    localparam logic [8:0] CMD_STATUS_FETCH = 9'h005;
    localparam logic [8:0] CMD_SETUP_STORE = 9'h001;

    // ----------------------------------------------------------------
    // mode setup register layout
    // ----------------------------------------------------------------
    localparam int SETUP_MODE_HI = 7;
    localparam int SETUP_MODE_LO = 6;
    localparam int SETUP_PAUSE_BIT = 0;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [1:0] PATTERN_BYTE = 2'h0;
    localparam logic [1:0] PATTERN_SEQ = 2'h1;
    localparam logic [1:0] PATTERN_PAGE = 2'h2;
    localparam logic [1:0] PATTERN_BAD = 2'h3;

    // ----------------------------------------------------------------
    // word formats and field lengths in bits
    // ----------------------------------------------------------------
    localparam logic [2:0] FMT_PLAIN = 3'h0;
    localparam logic [2:0] FMT_NINE = 3'h1;
    localparam logic [2:0] FMT_EVEN = 3'h2;
    localparam logic [2:0] FMT_ODD = 3'h3;
    localparam int FMT_ERR_BIT = 2;
    localparam logic [4:0] BITS_WORD8 = 5'h08;
    localparam logic [4:0] BITS_WORD9 = 5'h09;
    localparam logic [4:0] BITS_ADDR16 = 5'h10;
    localparam logic [4:0] BITS_ADDR18 = 5'h12;
    localparam logic [4:0] BITS_SETUP = 5'h09;
    localparam int MEM_ADDR_W = 15;
    localparam int PAGE_BITS = 5;

    // ----------------------------------------------------------------
    // host controller registers, byte addresses on the bus
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TX = 4'h4;
    localparam logic [3:0] REG_RX = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hc;
    localparam int CTRL_SELECT_BIT = 0;
    localparam int CTRL_PAUSE_BIT = 1;
    localparam int TX_COUNT_LO = 9;
    localparam int TX_COUNT_HI = 12;
    localparam int STAT_BUSY_BIT = 0;
    localparam logic [3:0] TX_COUNT_MAX = 4'h9;
    localparam int HALF_PERIOD_DEFAULT = 8;
endpackage

// ==== rtl/spi_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
    logic chip_select_n;
    logic sclk;
    logic mosi;
    logic pause_n;
    logic miso_out;
    logic miso_oe;
    logic miso;

    // undriven data line reads low, as with a weak pull-down
    assign miso = miso_oe & miso_out;

    modport device
    (
        input chip_select_n,
        input sclk,
        input mosi,
        input pause_n,
        output miso_out,
        output miso_oe
    );
    modport host
    (
        output chip_select_n,
        output sclk,
        output mosi,
        output pause_n,
        input miso
    );
endinterface
`default_nettype wire

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta;

    initial
    begin
        if (WIDTH < 1)
            $error("pin_sync needs at least one bit");
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= '0;
            level_o <= '0;
        end
        else
        begin
            meta <= pin_i;
            level_o <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/serial_sram_device.sv ====
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module serial_sram_device
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] word_format_sel_i,
    spi_link_if.device link
);
    import sram_spi_pkg::*;

    typedef enum {ST_CMD, ST_ADDR, ST_WRITE, ST_READ, ST_SETUP, ST_STATUS, ST_IGNORE} state_type;

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [6:0] pins;
    logic [2:0] fmt;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic pause_n;
    logic sclk_prev;
    logic rise;
    logic fall;

    pin_sync #(.WIDTH(7)) u_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({word_format_sel_i, link.chip_select_n, link.sclk, link.mosi, link.pause_n}),
        .level_o(pins)
    );
    assign {fmt, cs_n, sclk, mosi, pause_n} = pins;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sclk_prev <= 1'b0;
        else
            sclk_prev <= sclk;
    end

    // edges are not seen while paused, so every counter simply freezes
    assign rise = sclk & ~sclk_prev & ~cs_n & pause_n;
    assign fall = ~sclk & sclk_prev & ~cs_n & pause_n;

    // ----------------------------------------------------------------
    // format dependent lengths
    // ----------------------------------------------------------------
    logic nine;
    logic [4:0] word_last;
    logic [4:0] addr_last;

    assign nine = (fmt != FMT_PLAIN);
    assign word_last = (nine ? BITS_WORD9 : BITS_WORD8) - 5'h01;
    assign addr_last = (nine ? BITS_ADDR18 : BITS_ADDR16) - 5'h01;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    state_type state;
    logic [4:0] bit_cnt;
    logic [17:0] rx_shift;
    logic [8:0] tx_shift;
    logic is_read;
    logic drive;
    logic [MEM_ADDR_W-1:0] addr;
    logic [7:0] setup;
    logic [8:0] mem [0:(1<<MEM_ADDR_W)-1];

    logic [17:0] next_rx;
    logic [MEM_ADDR_W-1:0] next_addr;
    logic [MEM_ADDR_W-1:0] start_addr;
    logic [1:0] pattern;
    logic word_done;

    assign next_rx = {rx_shift[16:0], mosi};
    assign pattern = setup[SETUP_MODE_HI:SETUP_MODE_LO];
    assign word_done = (bit_cnt == word_last);

    // top address bit and the padding zeros are dropped here
    always_comb
    begin
        if (nine)
            start_addr = {next_rx[15:9], next_rx[7:0]};
        else
            start_addr = next_rx[MEM_ADDR_W-1:0];
    end

    always_comb
    begin
        case (pattern)
            PATTERN_SEQ:
                next_addr = addr + 15'h0001;
            PATTERN_PAGE:
                next_addr = {addr[MEM_ADDR_W-1:PAGE_BITS], addr[PAGE_BITS-1:0] + 5'h01};
            default:
                next_addr = addr;
        endcase
    end

    // ----------------------------------------------------------------
    // parity handling of the ninth stored bit
    // ----------------------------------------------------------------
    logic [8:0] store_word;
    logic [8:0] fetch_word;
    logic [8:0] status_word;

    always_comb
    begin
        store_word = {1'b0, next_rx[7:0]};
        if (fmt[FMT_ERR_BIT])
            store_word[8] = ^next_rx[7:0];
        else if (fmt == FMT_NINE)
            store_word[8] = next_rx[8];
        else if (fmt == FMT_EVEN)
            store_word[8] = ^next_rx[7:0];
        else if (fmt == FMT_ODD)
            store_word[8] = ~^next_rx[7:0];
    end

    function automatic logic [8:0] frame_out(input logic [8:0] q, input logic [2:0] f);
        logic [8:0] w;
        w = q;
        // error flag compares stored parity against a fresh calculation
        if (f[FMT_ERR_BIT])
            w[8] = q[8] ^ (^q[7:0]);
        // plain format never shows the ninth bit: data leaves from bit 8
        if (f == FMT_PLAIN)
            w = {q[7:0], 1'b0};
        return w;
    endfunction

    assign fetch_word = frame_out(mem[start_addr], fmt);
    assign status_word = nine ? {1'b0, setup} : {setup, 1'b0};

    // ----------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= ST_CMD;
            bit_cnt <= '0;
            rx_shift <= '0;
            is_read <= 1'b0;
            addr <= '0;
        end
        else if (cs_n)
        begin
            state <= ST_CMD;
            bit_cnt <= '0;
            rx_shift <= '0;
        end
        else if (rise)
        begin
            rx_shift <= next_rx;
            bit_cnt <= bit_cnt + 5'h01;
            case (state)
                ST_CMD:
                begin
                    if (word_done)
                    begin
                        bit_cnt <= '0;
                        is_read <= (next_rx[8:0] == CMD_READ);
                        case (next_rx[8:0])
                            CMD_READ,
                            CMD_WRITE:
                                state <= ST_ADDR;
                            CMD_STATUS_FETCH:
                                state <= ST_STATUS;
                            CMD_SETUP_STORE:
                                state <= ST_SETUP;
                            default:
                                state <= ST_IGNORE;
                        endcase
                    end
                end
                ST_ADDR:
                begin
                    if (bit_cnt == addr_last)
                    begin
                        bit_cnt <= '0;
                        addr <= start_addr;
                        state <= is_read ? ST_READ : ST_WRITE;
                    end
                end
                ST_WRITE,
                ST_READ,
                ST_STATUS:
                begin
                    if (word_done)
                    begin
                        bit_cnt <= '0;
                        if (state != ST_STATUS)
                            addr <= next_addr;
                    end
                end
                ST_SETUP:
                begin
                    if (bit_cnt == BITS_SETUP - 5'h01)
                        state <= ST_IGNORE;
                end
                default:
                    bit_cnt <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // setup register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            setup <= SETUP_RESET;
        else if (rise && state == ST_SETUP && bit_cnt == BITS_SETUP - 5'h01)
        begin
            if (next_rx[SETUP_MODE_HI:SETUP_MODE_LO] != PATTERN_BAD)
            begin
                setup <= '0;
                setup[SETUP_MODE_HI:SETUP_MODE_LO] <= next_rx[SETUP_MODE_HI:SETUP_MODE_LO];
                setup[SETUP_PAUSE_BIT] <= next_rx[SETUP_PAUSE_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // memory, written only when a whole word is in
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_i && rise && !cs_n && state == ST_WRITE && word_done)
            mem[addr] <= store_word;
    end

    // ----------------------------------------------------------------
    // serial output
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_shift <= '0;
            drive <= 1'b0;
        end
        else if (cs_n)
            drive <= 1'b0;
        else if (rise && state == ST_ADDR && bit_cnt == addr_last && is_read)
            tx_shift <= fetch_word;
        else if (rise && state == ST_CMD && word_done && next_rx[8:0] == CMD_STATUS_FETCH)
            tx_shift <= status_word;
        else if (rise && word_done && state == ST_READ)
            tx_shift <= frame_out(mem[next_addr], fmt);
        else if (rise && word_done && state == ST_STATUS)
            tx_shift <= status_word;
        else if (fall && (state == ST_READ || state == ST_STATUS))
        begin
            tx_shift <= {tx_shift[7:0], 1'b0};
            drive <= 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            link.miso_out <= 1'b0;
            link.miso_oe <= 1'b0;
        end
        else
        begin
            if (fall && (state == ST_READ || state == ST_STATUS))
                link.miso_out <= tx_shift[8];
            link.miso_oe <= ~cs_n & pause_n & (drive | fall) &
                (state == ST_READ || state == ST_STATUS);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/serial_sram_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_sram_host
#(
    parameter int HALF_PERIOD = sram_spi_pkg::HALF_PERIOD_DEFAULT
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    spi_link_if.host link
);
    import sram_spi_pkg::*;

    initial
    begin
        if (HALF_PERIOD < 8 || HALF_PERIOD > 255)
            $error("HALF_PERIOD must lie in 8..255");
    end

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic req;
    logic wr_ctrl;
    logic wr_tx;
    logic busy;
    logic [8:0] rx_word;
    logic miso_s;

    assign req = cyc_i & stb_i & ~ack_o;
    assign wr_ctrl = req & we_i & sel_i[0] & (adr_i == REG_CTRL);
    assign wr_tx = req & we_i & (&sel_i[1:0]) & (adr_i == REG_TX);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end
        else
        begin
            ack_o <= req;
            dat_o <= '0;
            if (req && !we_i)
            begin
                case (adr_i)
                    REG_CTRL:
                        dat_o <= {30'h0000_0000, ~link.pause_n, ~link.chip_select_n};
                    REG_RX:
                        dat_o <= {23'h00_0000, rx_word};
                    REG_STAT:
                        dat_o <= {31'h0000_0000, busy};
                    default:
                        dat_o <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // select and pause are software levels
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            link.chip_select_n <= 1'b1;
            link.pause_n <= 1'b1;
        end
        else if (wr_ctrl)
        begin
            link.chip_select_n <= ~dat_i[CTRL_SELECT_BIT];
            link.pause_n <= ~dat_i[CTRL_PAUSE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // shift engine, mode 0: data set on falling edge, taken on rising
    // ----------------------------------------------------------------
    pin_sync #(.WIDTH(1)) u_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(link.miso),
        .level_o(miso_s)
    );

    logic [7:0] div_cnt;
    logic tick;
    logic [3:0] bits_left;
    logic [8:0] tx_shift;
    logic [3:0] count_req;

    assign count_req = dat_i[TX_COUNT_HI:TX_COUNT_LO];
    // serial clock stalls while paused so the far end loses no bit
    assign tick = busy & link.pause_n & (div_cnt == 8'(HALF_PERIOD - 1));

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !busy || tick)
            div_cnt <= '0;
        else if (link.pause_n)
            div_cnt <= div_cnt + 8'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy <= 1'b0;
            bits_left <= '0;
            tx_shift <= '0;
            rx_word <= '0;
            link.sclk <= 1'b0;
            link.mosi <= 1'b0;
        end
        else if (!busy)
        begin
            // counts of 0 or above nine and writes while busy are dropped
            if (wr_tx && count_req != 4'h0 && count_req <= TX_COUNT_MAX)
            begin
                busy <= 1'b1;
                bits_left <= count_req;
                tx_shift <= dat_i[8:0] << (TX_COUNT_MAX - count_req);
                link.mosi <= dat_i[count_req - 4'h1];
                rx_word <= '0;
            end
        end
        else if (tick)
        begin
            if (!link.sclk)
                link.sclk <= 1'b1;
            else
            begin
                // sample late in the high phase to cover the return delay
                link.sclk <= 1'b0;
                rx_word <= {rx_word[7:0], miso_s};
                tx_shift <= {tx_shift[7:0], 1'b0};
                link.mosi <= tx_shift[7];
                bits_left <= bits_left - 4'h1;
                if (bits_left == 4'h1)
                    busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/serial_sram_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_sram_chk
#(
    parameter int HALF_PERIOD = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic pause_n,
    input wire logic miso_out,
    input wire logic miso_oe
);
    logic [7:0] hi_cnt;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ----
    // length of the clock's high phase, checked when it falls
    // ----
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !sclk)
        begin
            hi_cnt <= 8'h00;
        end
        else
        begin
            hi_cnt <= hi_cnt + 8'h01;
        end
    end

    sequence high_two;
        sclk ##1 sclk;
    endsequence

    half_period_a: assert property ($fell(sclk) |-> hi_cnt == 8'(HALF_PERIOD))
        else $error("serial clock high phase has the wrong length");
    deselect_quiet_a: assert property (chip_select_n [*4] |-> !miso_oe)
        else $error("data out driven while deselected");
    pause_quiet_a: assert property (!pause_n [*4] |-> !miso_oe)
        else $error("data out driven while paused");
    pause_freeze_a: assert property (!pause_n ##1 !pause_n |-> $stable(sclk))
        else $error("serial clock moved while paused");
    idle_clock_a: assert property (chip_select_n ##1 chip_select_n |-> !sclk)
        else $error("serial clock active outside a frame");
    mosi_hold_a: assert property (high_two |-> $stable(mosi))
        else $error("data in changed while clock high");
    miso_steady_a: assert property (high_two |-> $stable(miso_out))
        else $error("data out changed while clock high");
    oe_start_a: assert property ($rose(miso_oe) |-> !sclk && !chip_select_n && pause_n)
        else $error("data out enabled outside a falling clock phase");
endmodule
`default_nettype wire

// ==== dv/test_serial_sram_spi_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_serial_sram_spi_slave;
    import sram_spi_pkg::*;
    typedef struct {string what; logic [31:0] val;} expect_type;
    logic clk_i;
    logic rst_i;
    logic cyc;
    logic stb;
    logic we;
    logic chk_rd;
    logic ack;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [2:0] fmt;
    logic [4:0] w;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] rd_val;
    logic [8:0] s[3];
    expect_type exp_q[$];
    expect_type cur;
    int fail_count;
    int checks_done;
    int cycles;

    spi_link_if link();
    serial_sram_device u_serial_sram_device(.clk_i(clk_i), .rst_i(rst_i),
        .word_format_sel_i(fmt), .link(link));
    serial_sram_host #(.HALF_PERIOD(8)) u_serial_sram_host(.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .link(link));
    serial_sram_chk #(.HALF_PERIOD(8)) u_serial_sram_chk(.clk_i(clk_i), .rst_i(rst_i),
        .chip_select_n(link.chip_select_n), .sclk(link.sclk), .mosi(link.mosi),
        .pause_n(link.pause_n), .miso_out(link.miso_out), .miso_oe(link.miso_oe));

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // ----
    // reporting
    // ----
    task automatic compare(input string what, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, ex, got);
        end
    endtask

    task automatic tally_and_finish();
        // a note never matched by a read means a lost or missing result
        compare("pending_notes", 32'h0, 32'(exp_q.size()));
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic note(input string what, input logic [31:0] v);
        exp_q.push_back('{what, v});
    endtask

    // ----
    // bus and link tasks
    // ----
    task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] dv, input logic chk);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= dv;
        chk_rd <= chk;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd_val = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk_rd <= 1'b0;
    endtask

    // busy is polled, not timed: the word length depends on the format
    task automatic tx(input logic [8:0] v, input logic [4:0] n);
        wb(1'b1, REG_TX, {19'h0, n[3:0], v}, 1'b0);
        do wb(1'b0, REG_STAT, 32'h0, 1'b0); while (rd_val[STAT_BUSY_BIT] !== 1'b0);
    endtask

    task automatic rx(input string what, input logic [8:0] v);
        tx(9'h000, w);
        note(what, {23'h0, v & ((w == BITS_WORD8) ? 9'h0ff : 9'h1ff)});
        wb(1'b0, REG_RX, 32'h0, 1'b1);
    endtask

    task automatic cs(input logic on);
        wb(1'b1, REG_CTRL, {31'h0, on}, 1'b0);
        if (!on)
            repeat (4) @(posedge clk_i);
    endtask

    task automatic start(input logic [8:0] cmd, input logic [15:0] a);
        cs(1'b1);
        tx(cmd, w);
        tx({1'b0, a[15:8]}, w);
        tx({1'b0, a[7:0]}, w);
    endtask

    task automatic setup(input logic [7:0] v);
        cs(1'b1);
        tx(CMD_SETUP_STORE, w);
        tx({1'b0, v}, BITS_SETUP);
        cs(1'b0);
    endtask

    task automatic status(input logic [7:0] v);
        cs(1'b1);
        tx(CMD_STATUS_FETCH, w);
        rx("status", {1'b0, v});
        rx("status", {1'b0, v});
        cs(1'b0);
    endtask

    function automatic logic [8:0] word(input logic [8:0] sent);
        if (fmt == FMT_NINE)
            return sent;
        if (fmt == FMT_EVEN)
            return {^sent[7:0], sent[7:0]};
        if (fmt == FMT_ODD)
            return {~^sent[7:0], sent[7:0]};
        return {1'b0, sent[7:0]};
    endfunction

    // ----
    // result watcher and hang guard
    // ----
    always @(posedge clk_i)
    begin
        cycles++;
        if (ack === 1'b1 && chk_rd === 1'b1)
        begin
            if (exp_q.size() > 0)
            begin
                cur = exp_q.pop_front();
                compare(cur.what, cur.val, rdat);
            end
            else
                compare("queue_size", 32'h1, 32'h0);
        end
        if (cycles > 90000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        chk_rd = 1'b0;
        adr = 4'h0;
        sel = 4'hf;
        wdat = 32'h0;
        fmt = 3'h0;
        fail_count = 0;
        checks_done = 0;
        cycles = 0;
        void'($urandom(44));
        for (int f = 0; f < 5; f++)
        begin
            @(posedge clk_i);
            rst_i <= 1'b1;
            fmt <= (f == 4) ? 3'h4 + 3'($urandom_range(3, 0)) : 3'(f);
            w = (f == 0) ? BITS_WORD8 : BITS_WORD9;
            repeat (16) @(posedge clk_i);
            rst_i <= 1'b0;
            status(8'h00);
            setup(8'h41);
            status(8'h41);
            setup(8'hc0);
            status(8'h41);
            for (int i = 0; i < 3; i++)
                s[i] = 9'($urandom);
            start(CMD_WRITE, 16'hfffe);
            for (int i = 0; i < 3; i++)
                tx(s[i], w);
            cs(1'b0);
            start(CMD_WRITE, 16'h7fff);
            tx(9'($urandom), 5'h05);
            cs(1'b0);
            start(CMD_READ, 16'h7ffe);
            for (int i = 0; i < 3; i++)
            begin
                if (i == 1)
                begin
                    wb(1'b1, REG_CTRL, 32'h3, 1'b0);
                    repeat (40) @(posedge clk_i);
                    note("ctrl", 32'h3);
                    wb(1'b0, REG_CTRL, 32'h0, 1'b1);
                    wb(1'b1, REG_CTRL, 32'h1, 1'b0);
                end
                rx("seq_word", word(s[i]));
            end
            cs(1'b0);
            setup(8'h80);
            start(CMD_WRITE, 16'h0a1f);
            tx(s[2], w);
            tx(s[0], w);
            cs(1'b0);
            start(CMD_READ, 16'h0a00);
            rx("page_word", word(s[0]));
            cs(1'b0);
            setup(8'h00);
            start(CMD_READ, 16'h7fff);
            rx("byte_word", word(s[1]));
            rx("byte_word", word(s[1]));
            cs(1'b0);
            cs(1'b1);
            tx(9'h0ff, w);
            tx(9'h000, w);
            rx("nop_word", 9'h000);
            cs(1'b0);
            note("ctrl", 32'h0);
            wb(1'b0, REG_CTRL, 32'h0, 1'b1);
            note("unmapped", 32'h0);
            wb(1'b0, 4'h2, 32'h0, 1'b1);
            $display("format test %0d finished", f);
        end
        repeat (4) @(posedge clk_i);
        tally_and_finish();
    end
endmodule
`default_nettype wire
